// ==== shared/cmp_one_consts.vh ====
`ifndef CMP_ONE_CONSTS_VH
`define CMP_ONE_CONSTS_VH

// Register indexes; byte address is four times the index
`define CMP_IDX_CTRL 10'h119
`define CMP_IDX_STATUS 10'h120
`define CMP_IDX_MASK 10'h121
`define CMP_IDX_PINCFG 10'h122

// Control register field positions
`define CMP_BIT_ENABLE 7
`define CMP_BIT_RESULT 6
`define CMP_BIT_PIN_OE 5
`define CMP_BIT_INVERT 4
`define CMP_BIT_SPEED 3
`define CMP_BIT_REF 2
`define CMP_BIT_CH_HI 1
`define CMP_BIT_CH_LO 0

// Status and mask field positions
`define CMP_BIT_EV_CHANGE 0

// Pin configuration field positions
`define CMP_BIT_DIR 4
`define CMP_BIT_ANSEL_HI 3
`define CMP_BIT_ANSEL_LO 0

// Reset values
`define CMP_RST_CTRL 8'h00
`define CMP_RST_STATUS 1'h0
`define CMP_RST_MASK 1'h0
`define CMP_RST_PINCFG 5'h10

// Clock periods per instruction cycle
`define CMP_CYCLE_CLKS 4

`endif

// ==== core/cmp_sync2.v ====
`timescale 1ns/1ps
// Two-flop synchroniser for a level from outside the clock domain
module cmp_sync2 (
    input wire pclk,
    input wire presetn,
    input wire async_in,
    output wire sync_out
);
    reg first_reg; // Metastable stage, read only by second stage
    reg second_reg; // Settled level

    // Shift the level through two flops
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_reg <= 1'b0;
            second_reg <= 1'b0;
        end else begin
            first_reg <= async_in;
            second_reg <= first_reg;
        end
    end

    assign sync_out = second_reg;
endmodule // cmp_sync2

// ==== core/cmp_cycle_div.v ====
`timescale 1ns/1ps
// Instruction-cycle enable: one-cycle pulse every DIV clocks
module cmp_cycle_div #(
    parameter DIV = 4
) (
    input wire pclk,
    input wire presetn,
    output wire cycle_end
);
    localparam W = (DIV > 1) ? $clog2(DIV) : 1;
    localparam integer LAST_INT = DIV - 1; // Final count at full width
    localparam [W-1:0] LAST = LAST_INT[W-1:0]; // Cut to the counter width on purpose

    reg [W-1:0] count_reg; // Position inside the instruction cycle
    reg pulse_reg; // End-of-cycle strobe

    // Count clocks and flag the final one
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= {W{1'b0}};
            pulse_reg <= 1'b0;
        end else if (count_reg == LAST) begin
            count_reg <= {W{1'b0}};
            pulse_reg <= 1'b1;
        end else begin
            count_reg <= count_reg + {{(W-1){1'b0}}, 1'b1};
            pulse_reg <= 1'b0;
        end
    end

    assign cycle_end = pulse_reg;
endmodule // cmp_cycle_div

// ==== core/cmp_one_ctrl.v ====
// Summary of operation
// - Enable bit 7 turns comparator on
// - Bits 1-0 pick one of four inputs
// - Bit 2 picks internal or pin reference
// - Bit 6 is read-only result flag
// - Bit 4 inverts the compare result
// - Bit 5 routes result to pin
// - Pin driven when oe, enable, direction output
// - Bit 3 set normal, clear low power
// - Flag latched per cycle, pin unlatched
// - Interrupt independent of pin output enable
`timescale 1ns/1ps
`include "cmp_one_consts.vh"

module cmp_one_ctrl #(
    parameter CYCLE_CLKS = `CMP_CYCLE_CLKS
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire cmp_raw,
    output wire cmp_enable,
    output wire [1:0] cmp_channel_sel,
    output wire cmp_ref_sel,
    output wire cmp_speed_sel,
    output wire [3:0] analog_pin_select,
    output wire cmp_pin_out,
    output wire cmp_pin_oe,
    output wire irq
);

    // Control register fields
    reg cmp_enable_reg; // Comparator on
    reg cmp_pin_output_enable_reg; // Result allowed onto pin
    reg cmp_invert_reg; // Output polarity
    reg cmp_speed_sel_reg; // 1 normal speed, 0 low power
    reg cmp_ref_sel_reg; // 1 internal reference, 0 plus pin
    reg [1:0] cmp_channel_sel_reg; // Inverting input choice
    reg cmp_result_reg; // Latched result flag

    // Own registers
    // Pin setup and interrupt words sit beside the control word
    reg porta_direction_reg; // Pin direction, 1 input
    reg [3:0] analog_pin_select_reg; // Analog mode of the four pins
    reg status_reg; // Sticky change event
    reg mask_reg; // Interrupt enable for the event

    // Outputs held in flops
    reg pin_out_reg; // Unlatched result toward pin
    reg pin_oe_reg; // Pin driver enable
    reg irq_reg; // Level interrupt
    reg [31:0] prdata_reg; // Read data
    reg pready_reg; // Access phase answer
    reg pslverr_reg; // Error answer

    // Internal nets
    wire raw_sync; // Synchronised compare input
    wire cycle_end; // Instruction-cycle boundary
    wire pol_result; // Compare after gating and inversion
    // Bus decode nets
    wire setup_phase; // First cycle of a transfer
    wire access_done; // Edge where the transfer completes
    wire [9:0] reg_index; // Word index of the address
    wire addr_aligned; // Low address bits are zero
    wire hit_ctrl; // Control register selected
    wire hit_status; // Status register selected
    wire hit_mask; // Mask register selected
    wire hit_pincfg; // Pin configuration selected
    wire hit_any; // Any mapped register selected
    // Write strobes
    wire wr_ctrl; // Control write strobe
    wire wr_status; // Status clear strobe
    wire wr_mask; // Mask write strobe
    wire wr_pincfg; // Pin configuration write strobe
    // Event and read path nets
    wire change_event; // Latched result about to change
    wire [7:0] ctrl_view; // Control register as read
    reg [31:0] read_mux; // Read data chosen at setup
    reg status_next; // Next sticky status

    // Reset images of the registers, split into fields below
    localparam [7:0] RST_CTRL = `CMP_RST_CTRL;
    localparam [4:0] RST_PINCFG = `CMP_RST_PINCFG;

    // Bring the analog compare into the clock domain
    // The compare output has no relation to pclk, so two flops
    // keep a metastable level away from the logic
    cmp_sync2 u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(cmp_raw),
        .sync_out(raw_sync)
    );

    // Instruction-cycle pulse for the result latch
    // Keeps the flag from following the comparator mid-cycle
    cmp_cycle_div #(
        .DIV(CYCLE_CLKS)
    ) u_div (
        .pclk(pclk),
        .presetn(presetn),
        .cycle_end(cycle_end)
    );

    // Disabled comparator reads as low, then polarity applied
    // A powered-down comparator output is meaningless; forcing it
    // low keeps the flag and the pin predictable
    assign pol_result = (raw_sync & cmp_enable_reg) ^ cmp_invert_reg;

    // Bus decode
    // Offsets are word indexes; the byte address is four times that
    // Misaligned addresses never hit a register
    assign setup_phase = psel & ~penable;
    assign access_done = psel & penable & pready_reg;
    assign reg_index = paddr[11:2];
    assign addr_aligned = (paddr[1:0] == 2'h0);
    assign hit_ctrl = addr_aligned & (reg_index == `CMP_IDX_CTRL);
    assign hit_status = addr_aligned & (reg_index == `CMP_IDX_STATUS);
    assign hit_mask = addr_aligned & (reg_index == `CMP_IDX_MASK);
    assign hit_pincfg = addr_aligned & (reg_index == `CMP_IDX_PINCFG);
    assign hit_any = hit_ctrl | hit_status | hit_mask | hit_pincfg;

    // Writes land only on the completing edge, never on errors
    // A setup cycle alone never changes any register
    assign wr_ctrl = access_done & pwrite & hit_ctrl;
    assign wr_status = access_done & pwrite & hit_status;
    assign wr_mask = access_done & pwrite & hit_mask;
    assign wr_pincfg = access_done & pwrite & hit_pincfg;

    // Event when the latched flag is about to take a new value
    // Comparing with the flag, not the raw input, gives one event
    // for each change that software can see
    assign change_event = cycle_end & (pol_result != cmp_result_reg);

    // Control register view with live result flag
    // Bit 6 comes from the latch, never from write data
    assign ctrl_view = {cmp_enable_reg, cmp_result_reg, cmp_pin_output_enable_reg,
                        cmp_invert_reg, cmp_speed_sel_reg, cmp_ref_sel_reg,
                        cmp_channel_sel_reg};

    // Read data selection
    // Unmapped offsets read as zero
    // Chosen at setup so the data stands through the access phase
    always @* begin
        read_mux = 32'h0000_0000;
        if (hit_ctrl) begin
            read_mux[7:0] = ctrl_view;
        end else if (hit_status) begin
            read_mux[`CMP_BIT_EV_CHANGE] = status_reg;
        end else if (hit_mask) begin
            read_mux[`CMP_BIT_EV_CHANGE] = mask_reg;
        end else if (hit_pincfg) begin
            read_mux[`CMP_BIT_DIR] = porta_direction_reg;
            read_mux[`CMP_BIT_ANSEL_HI:`CMP_BIT_ANSEL_LO] = analog_pin_select_reg;
        end
    end

    // Sticky status: a new event beats a clear in the same cycle
    // Otherwise software clearing as an event lands would lose it
    // and the interrupt would never come
    always @* begin
        status_next = status_reg;
        if (wr_status && pwdata[`CMP_BIT_EV_CHANGE]) begin
            status_next = 1'b0; // Write one to clear
        end
        if (change_event) begin
            status_next = 1'b1; // Set wins
        end
    end

    // APB answer: one wait-free access phase after setup
    // Error flag and read data are caught together at setup,
    // so they stand unchanged through the access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Idle bus: no answer pending
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else if (setup_phase) begin
            // Answer in the very next cycle
            pready_reg <= 1'b1;
            pslverr_reg <= ~hit_any;
            prdata_reg <= pwrite ? 32'h0000_0000 : read_mux;
        end else begin
            // Drop the answer; read data stays until the next setup
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end
    end

    // Control register writes; result position is ignored
    // Only six fields have storage, so bit 6 has nothing to land in
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Every control field powers up cleared
            cmp_enable_reg <= RST_CTRL[`CMP_BIT_ENABLE];
            cmp_pin_output_enable_reg <= RST_CTRL[`CMP_BIT_PIN_OE];
            cmp_invert_reg <= RST_CTRL[`CMP_BIT_INVERT];
            cmp_speed_sel_reg <= RST_CTRL[`CMP_BIT_SPEED];
            cmp_ref_sel_reg <= RST_CTRL[`CMP_BIT_REF];
            cmp_channel_sel_reg <= RST_CTRL[`CMP_BIT_CH_HI:`CMP_BIT_CH_LO];
        end else if (wr_ctrl) begin
            // Completing write to the control word
            cmp_enable_reg <= pwdata[`CMP_BIT_ENABLE];
            cmp_pin_output_enable_reg <= pwdata[`CMP_BIT_PIN_OE];
            cmp_invert_reg <= pwdata[`CMP_BIT_INVERT];
            cmp_speed_sel_reg <= pwdata[`CMP_BIT_SPEED];
            cmp_ref_sel_reg <= pwdata[`CMP_BIT_REF];
            cmp_channel_sel_reg <= pwdata[`CMP_BIT_CH_HI:`CMP_BIT_CH_LO];
        end
    end

    // Result flag follows the comparator only at cycle ends
    // Polarity is already applied, so the flag reads as software
    // expects it without further decoding
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Flag starts low, matching a disabled comparator
            cmp_result_reg <= RST_CTRL[`CMP_BIT_RESULT];
        end else if (cycle_end) begin
            cmp_result_reg <= pol_result;
        end
    end

    // Pin direction and analog selects
    // Direction resets to input so the pin is never driven
    // before software asks for it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Input direction, all pins digital
            porta_direction_reg <= RST_PINCFG[`CMP_BIT_DIR];
            analog_pin_select_reg <= RST_PINCFG[`CMP_BIT_ANSEL_HI:`CMP_BIT_ANSEL_LO];
        end else if (wr_pincfg) begin
            porta_direction_reg <= pwdata[`CMP_BIT_DIR];
            analog_pin_select_reg <= pwdata[`CMP_BIT_ANSEL_HI:`CMP_BIT_ANSEL_LO];
        end
    end

    // Interrupt status and mask
    // Status holds until cleared; the mask only gates the line
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // No event pending, interrupt masked
            status_reg <= `CMP_RST_STATUS;
            mask_reg <= `CMP_RST_MASK;
        end else begin
            status_reg <= status_next;
            if (wr_mask) begin
                mask_reg <= pwdata[`CMP_BIT_EV_CHANGE];
            end
        end
    end

    // Interrupt level, unaffected by pin output enable
    // Registered so the line is free of glitches
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Line idle low
            irq_reg <= 1'b0;
        end else begin
            // Pending event gated by its mask
            irq_reg <= status_reg & mask_reg;
        end
    end

    // Pin path: unlatched result, drive enable gated by all three conditions
    // The pin skips the instruction-cycle latch; the output flop
    // costs one clock but keeps the pin free of glitches
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Pin released and low
            pin_out_reg <= 1'b0;
            pin_oe_reg <= 1'b0;
        end else begin
            // Follow the comparator on every clock
            pin_out_reg <= pol_result;
            pin_oe_reg <= cmp_pin_output_enable_reg & cmp_enable_reg
                          & ~porta_direction_reg;
        end
    end

    // Port drive, all from flops
    // No logic stands between these flops and the ports
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign cmp_enable = cmp_enable_reg;
    assign cmp_channel_sel = cmp_channel_sel_reg;
    assign cmp_ref_sel = cmp_ref_sel_reg;
    assign cmp_speed_sel = cmp_speed_sel_reg;
    assign analog_pin_select = analog_pin_select_reg;
    assign cmp_pin_out = pin_out_reg;
    assign cmp_pin_oe = pin_oe_reg;
    assign irq = irq_reg;

endmodule // cmp_one_ctrl

// ==== verif/cmp_one_ctrl_properties.sv ====
`timescale 1ns/1ps
`include "cmp_one_consts.vh"
// Port checks for the comparator control block
module cmp_one_ctrl_checker #(
    parameter CYCLE_CLKS = 4
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire cmp_raw,
    input wire cmp_enable,
    input wire [1:0] cmp_channel_sel,
    input wire cmp_ref_sel,
    input wire cmp_speed_sel,
    input wire [3:0] analog_pin_select,
    input wire cmp_pin_out,
    input wire cmp_pin_oe,
    input wire irq
);
    localparam [11:0] A_CTRL = {`CMP_IDX_CTRL, 2'b00};
    wire wr_done = psel & penable & pready & pwrite; // Completed write
    wire [4:0] wr_ctl = {pwdata[7], pwdata[3:0]}; // Written config fields
    reg [2:0] quiet_reg; // Cycles since last write, saturating
    // Quiet time lets pin changes be traced to the raw input
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) quiet_reg <= 3'h0;
        else if (wr_done) quiet_reg <= 3'h0;
        else if (quiet_reg != 3'h7) quiet_reg <= quiet_reg + 3'h1;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_pready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready not a single cycle after setup");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    a_err_data_zero: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response with data");
    a_ctrl_read_view: assert property (pready && !pwrite && paddr == A_CTRL |->
        prdata[31:8] == 24'h0 && prdata[7] == cmp_enable && prdata[3:0] ==
        {cmp_speed_sel, cmp_ref_sel, cmp_channel_sel}) else $error("control read mismatch");
    a_ctrl_write_take: assert property (wr_done && paddr == A_CTRL |=>
        {cmp_enable, cmp_speed_sel, cmp_ref_sel, cmp_channel_sel} == $past(wr_ctl))
        else $error("control write not applied");
    a_oe_needs_on: assert property (cmp_pin_oe |-> cmp_enable || $past(cmp_enable))
        else $error("pin driven while comparator off");
    a_pin_from_raw: assert property (quiet_reg == 3'h7 && $changed(cmp_pin_out) |->
        $past(cmp_raw, 3) != $past(cmp_raw, 4)) else $error("pin changed without cause");
    a_pin_sees_raw: assert property (quiet_reg == 3'h7 && cmp_enable &&
        $past(cmp_raw, 3) != $past(cmp_raw, 4) |-> $changed(cmp_pin_out))
        else $error("pin missed a raw change");
    a_misaligned_err: assert property (psel && !penable && paddr[1:0] != 2'h0 |=>
        pslverr && prdata == 32'h0) else $error("misaligned access not refused");
    c_pin_tracks: cover property (quiet_reg == 3'h7 && $changed(cmp_pin_out));
    c_ctrl_write: cover property (wr_done && paddr == A_CTRL);
    c_irq_rise: cover property ($rose(irq));
    c_refused: cover property (pslverr);
endmodule // cmp_one_ctrl_checker

// ==== verif/cmp_analog_model.sv ====
`timescale 1ns/1ps
// Analog front end: muxes pins and references, compares them
module cmp_analog_model (
    input wire cmp_enable,
    input wire [1:0] cmp_channel_sel,
    input wire cmp_ref_sel,
    input wire [3:0] analog_pin_select,
    input wire [31:0] pin_v,
    input wire [7:0] plus_v,
    input wire [7:0] vref_v,
    output wire cmp_raw
);
    // Pin left digital loads the input high
    wire [7:0] vn = analog_pin_select[cmp_channel_sel] ?
        pin_v[cmp_channel_sel*8 +: 8] : 8'hff;
    wire [7:0] vp = cmp_ref_sel ? vref_v : plus_v;
    wire hit = vp > vn;
    // Output of a powered-down comparator is junk
    assign cmp_raw = cmp_enable ? hit : ~hit;
endmodule // cmp_analog_model

// ==== verif/tb_cmp_one_ctrl.sv ====
`timescale 1ns/1ps
`include "cmp_one_consts.vh"
// Bench for the comparator control block
module tb_cmp_one_ctrl;
    localparam [11:0] A_CTRL = {`CMP_IDX_CTRL, 2'b00};
    localparam [11:0] A_STAT = {`CMP_IDX_STATUS, 2'b00};
    localparam [11:0] A_MASK = {`CMP_IDX_MASK, 2'b00};
    localparam [11:0] A_PCFG = {`CMP_IDX_PINCFG, 2'b00};
    reg pclk = 1'b0;
    reg presetn = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [11:0] paddr = 12'h0;
    reg [31:0] pwdata = 32'h0;
    reg [31:0] pin_v = {8'hd2, 8'h96, 8'h5a, 8'h1e}; // Inverting pin levels
    reg [7:0] plus_v = 8'h78; // Plus pin level
    reg [7:0] vref_v = 8'h3c; // Internal reference level
    wire [31:0] prdata;
    wire pready, pslverr, cmp_raw, cmp_enable, cmp_ref_sel, cmp_speed_sel;
    wire cmp_pin_out, cmp_pin_oe, irq;
    wire [1:0] cmp_channel_sel;
    wire [3:0] analog_pin_select;
    wire [4:0] cfg_seen = {cmp_enable, cmp_speed_sel, cmp_ref_sel, cmp_channel_sel}; // Outputs
    integer err_total = 0;
    integer checks = 0;
    integer cycles = 0;
    integer i;
    reg [31:0] rd; // Last read data
    reg se; // Last error response
    reg [7:0] cv; // Control value written
    reg [7:0] vp; // Expected noninverting level
    reg er; // Expected result
    always #5 pclk = ~pclk;
    cmp_one_ctrl #(.CYCLE_CLKS(4)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cmp_raw(cmp_raw), .cmp_enable(cmp_enable),
        .cmp_channel_sel(cmp_channel_sel), .cmp_ref_sel(cmp_ref_sel),
        .cmp_speed_sel(cmp_speed_sel), .analog_pin_select(analog_pin_select),
        .cmp_pin_out(cmp_pin_out), .cmp_pin_oe(cmp_pin_oe), .irq(irq));
    cmp_analog_model u_ana (.cmp_enable(cmp_enable), .cmp_channel_sel(cmp_channel_sel),
        .cmp_ref_sel(cmp_ref_sel), .analog_pin_select(analog_pin_select), .pin_v(pin_v),
        .plus_v(plus_v), .vref_v(vref_v), .cmp_raw(cmp_raw));
    // One APB transfer, held until pready
    task apb(input reg wr, input reg [11:0] a, input reg [31:0] d);
        begin
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) @(posedge pclk);
            rd = prdata;
            se = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    // Compare seen against expected
    task chk(input reg [31:0] got, input reg [31:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // Read a register and compare
    task rdchk(input reg [11:0] a, input reg [31:0] exp);
        begin
            apb(1'b0, a, 32'h0);
            chk(rd, exp);
        end
    endtask
    // Counts, verdict, stop
    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", checks, err_total);
            if (err_total == 0 && checks > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    // Hang guard
    always @(posedge pclk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            err_total = err_total + 1;
            end_of_test;
        end
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(A_CTRL, 32'h0);
        rdchk(A_PCFG, 32'h10);
        $display("test reset done");
        apb(1'b1, A_PCFG, 32'h0f);
        rdchk(A_PCFG, 32'h0f);
        chk({28'h0, analog_pin_select}, 32'hf);
        // Sweep channel, reference, polarity; bit 6 written as one
        for (i = 0; i < 16; i = i + 1) begin
            cv = {3'h7, i[3], 1'b1, i[2], i[1:0]};
            vp = i[2] ? vref_v : plus_v;
            er = (vp > pin_v[i[1:0]*8 +: 8]) ^ i[3];
            apb(1'b1, A_CTRL, {24'h0, cv});
            repeat (10) @(posedge pclk);
            chk({31'h0, cmp_pin_out}, {31'h0, er});
            chk({31'h0, cmp_pin_oe}, 32'h1);
            chk({27'h0, cfg_seen}, {27'h0, cv[7], cv[3:0]});
            rdchk(A_CTRL, {24'h0, cv[7], er, cv[5:0]});
        end
        $display("test sweep done");
        apb(1'b1, A_CTRL, 32'h30);
        repeat (10) @(posedge pclk);
        chk({31'h0, cmp_pin_oe}, 32'h0);
        chk({31'h0, cmp_pin_out}, 32'h1);
        chk({31'h0, cmp_speed_sel}, 32'h0);
        rdchk(A_CTRL, 32'h70);
        apb(1'b1, A_CTRL, 32'h88);
        repeat (10) @(posedge pclk);
        chk({31'h0, cmp_pin_oe}, 32'h0);
        chk({31'h0, cmp_pin_out}, 32'h1);
        chk({31'h0, cmp_speed_sel}, 32'h1);
        apb(1'b1, A_PCFG, 32'h1f);
        apb(1'b1, A_CTRL, 32'ha8);
        repeat (10) @(posedge pclk);
        chk({31'h0, cmp_pin_oe}, 32'h0);
        $display("test pin gating done");
        // Interrupt with pin output off; pin changes wait out the checker's quiet time
        apb(1'b1, A_CTRL, 32'h88);
        repeat (10) @(posedge pclk);
        apb(1'b1, A_STAT, 32'h1);
        apb(1'b1, A_MASK, 32'h1);
        chk({31'h0, irq}, 32'h0);
        repeat (8) @(posedge pclk);
        pin_v[7:0] <= 8'hc8;
        repeat (10) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        rdchk(A_STAT, 32'h1);
        apb(1'b1, A_STAT, 32'h1);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, A_MASK, 32'h0);
        repeat (8) @(posedge pclk);
        pin_v[7:0] <= 8'h1e;
        repeat (10) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        rdchk(A_STAT, 32'h1);
        $display("test interrupt done");
        // Reset in mid-run clears status, control and pin drive
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(A_STAT, 32'h0);
        rdchk(A_CTRL, 32'h0);
        chk({31'h0, cmp_pin_oe}, 32'h0);
        $display("test mid reset done");
        rdchk(12'h400, 32'h0);
        chk({31'h0, se}, 32'h1);
        apb(1'b1, 12'h465, 32'hff);
        chk({31'h0, se}, 32'h1);
        rdchk(A_CTRL, 32'h0);
        $display("test unmapped done");
        end_of_test;
    end
endmodule // tb_cmp_one_ctrl
bind cmp_one_ctrl cmp_one_ctrl_checker #(.CYCLE_CLKS(CYCLE_CLKS)) u_chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmp_raw(cmp_raw),
    .cmp_enable(cmp_enable), .cmp_channel_sel(cmp_channel_sel), .cmp_ref_sel(cmp_ref_sel),
    .cmp_speed_sel(cmp_speed_sel), .analog_pin_select(analog_pin_select),
    .cmp_pin_out(cmp_pin_out), .cmp_pin_oe(cmp_pin_oe), .irq(irq));
